//--- src/tsc_pkg.sv
package tsc_pkg;

    // Bus widths
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [31:0] CTRL_ADDR = 32'h0000_215C;
    localparam logic [31:0] STAT_ADDR = 32'h0000_21FC;

    // Reset values of the registers and idle read data, and writable bits of the control register
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_0B7F;
    localparam logic [31:0] STAT_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_IDLE  = 32'h0000_0000;

    // Control register field positions
    localparam int unsigned BIT_ANALOG_INPUT_PIN_ZERO   = 0;
    localparam int unsigned BIT_ANALOG_INPUT_PIN_ONE   = 1;
    localparam int unsigned BIT_ANALOG_INPUT_PIN_TWO   = 2;
    localparam int unsigned BIT_ANALOG_INPUT_PIN_THREE   = 3;
    localparam int unsigned BIT_SENSE  = 4;
    localparam int unsigned BIT_CAL_DE = 5;
    localparam int unsigned BIT_SPARE  = 6;
    localparam int unsigned BIT_GROUP  = 8;
    localparam int unsigned BIT_DIRECT = 9;
    localparam int unsigned BIT_CAL1   = 11;

    // Number of switches that sit behind the group path
    localparam int unsigned GROUP_N = 6;

    // Status register field positions
    localparam int unsigned STAT_REACH_LSB = 0;
    localparam int unsigned STAT_DIRECT    = 6;
    localparam int unsigned STAT_CAL1      = 7;
    localparam int unsigned STAT_CONF_LIVE = 8;
    localparam int unsigned STAT_CONF_HELD = 9;

    // Exact address match used by every decoder
    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] target);
        addr_hit = (addr == target);
    endfunction

endpackage

//--- src/tsc_core_if.sv
`timescale 1ns/1ns
interface tsc_core_if;

    // Bus request as seen by the decoder
    logic [31:0]                    addr;
    logic                           wr;
    logic                           rd;
    // Decoded selects
    logic                           ctrl_wr;
    logic                           ctrl_rd;
    logic                           stat_wr;
    logic                           stat_rd;
    // Switch state and evaluated paths
    logic [31:0]                    ctrl;
    logic [tsc_pkg::GROUP_N-1:0]    group_reach;
    logic                           direct_reach;
    logic                           conflict;

    modport owner (
        output addr, wr, rd, ctrl,
        input  ctrl_wr, ctrl_rd, stat_wr, stat_rd,
        input  group_reach, direct_reach, conflict
    );
    modport dec (
        input  addr, wr, rd,
        output ctrl_wr, ctrl_rd, stat_wr, stat_rd
    );
    modport eval (
        input  ctrl,
        output group_reach, direct_reach, conflict
    );

endinterface

//--- src/tsc_addr_dec.sv
`timescale 1ns/1ns
module tsc_addr_dec (
    tsc_core_if.dec bus    // Request in, selects out
);

    // Decode strobes against the two mapped words
    assign bus.ctrl_wr = bus.wr && tsc_pkg::addr_hit(bus.addr, tsc_pkg::CTRL_ADDR);
    assign bus.ctrl_rd = bus.rd && tsc_pkg::addr_hit(bus.addr, tsc_pkg::CTRL_ADDR);
    assign bus.stat_wr = bus.wr && tsc_pkg::addr_hit(bus.addr, tsc_pkg::STAT_ADDR);
    assign bus.stat_rd = bus.rd && tsc_pkg::addr_hit(bus.addr, tsc_pkg::STAT_ADDR);

endmodule

//--- src/tsc_path_eval.sv
`timescale 1ns/1ns
module tsc_path_eval (
    tsc_core_if.eval sw    // Switch word in, paths out
);

    logic group_closed;

    // Group switches only reach the amplifier through the group path
    assign group_closed = sw.ctrl[tsc_pkg::BIT_GROUP];
    assign sw.group_reach = group_closed ?
        sw.ctrl[tsc_pkg::GROUP_N-1:0] : '0;    // [R4]

    // Drive electrode reaches the amplifier directly when its switch closes
    assign sw.direct_reach = sw.ctrl[tsc_pkg::BIT_DIRECT];    // [R4]

    // Both paths closed together is an illegal setting
    assign sw.conflict = group_closed && sw.ctrl[tsc_pkg::BIT_DIRECT];    // [R5]

endmodule

//--- src/tsc_switch_ctrl.sv
`timescale 1ns/1ns
// What this block does
// R1: Control register at 0x0000215C, reset to zero so all switches start open.
// R2: Bit 11 closes switch joining calibration pin one to amplifier input.
// R3: Bit 9 closes direct switch from drive electrode to amplifier input.
// R4: With group path open, drive electrode reaches amplifier only via direct switch.
// R5: Software keeps direct switch open whenever group path bit is set.
// R6: Bit 6 closes the spare group switch.
// R7: Bit 5 closes calibration path onto drive electrode input.
// R8: Bit 4 closes sense electrode switch through group path.
// R9: Bit 3 closes analog input three switch through group path.
// R10: Bit 2 closes analog input two switch through group path.
// R11: Bit 1 closes analog input one switch through group path.
// R12: Bit 0 closes analog input zero switch through group path.
// R13: Reserved bits read zero, ignore writes; switch outputs follow stored bits.
module tsc_switch_ctrl (
    input  wire logic        CORE_CLK_IN,                          // 250 MHz clock
    input  wire logic        RST_N_IN,                             // Async reset, low
    input  wire logic [31:0] ADDR_IN,                              // Byte address
    input  wire logic [31:0] WDATA_IN,                             // Write data
    input  wire logic        WR_EN_IN,                             // Write strobe
    input  wire logic        RD_EN_IN,                             // Read strobe
    output logic      [31:0] RDATA_OUT,                            // Read data, next cycle
    output logic             CAL_RESISTOR_ONE_SWITCH_OUT,          // Closed when high
    output logic             DIRECT_DRIVE_ELECTRODE_SWITCH_OUT,    // Closed when high
    output logic             GROUP_PATH_SWITCH_OUT,                // Closed when high
    output logic             SPARE_GROUP_SWITCH_OUT,               // Closed when high
    output logic             CAL_TO_DRIVE_ELECTRODE_SWITCH_OUT,    // Closed when high
    output logic             SENSE_ELECTRODE_SWITCH_OUT,           // Closed when high
    output logic             ANALOG_INPUT_THREE_SWITCH_OUT,        // Closed when high
    output logic             ANALOG_INPUT_TWO_SWITCH_OUT,          // Closed when high
    output logic             ANALOG_INPUT_ONE_SWITCH_OUT,          // Closed when high
    output logic             ANALOG_INPUT_ZERO_SWITCH_OUT,         // Closed when high
    output logic             PATH_CONFLICT_OUT                     // Held illegal setting
);

    tsc_core_if core ();

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic        conf_held_reg;
    logic        conf_held_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] stat_word;

    // Bus request handed to the decoder
    assign core.addr = ADDR_IN;
    assign core.wr   = WR_EN_IN;
    assign core.rd   = RD_EN_IN;
    assign core.ctrl = ctrl_reg;

    tsc_addr_dec u_dec (
        .bus (core.dec)
    );

    tsc_path_eval u_eval (
        .sw  (core.eval)
    );

    // Next control word: only implemented bits can be written
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (core.ctrl_wr)
        begin
            ctrl_next = WDATA_IN & tsc_pkg::CTRL_MASK;    // [R13]
        end
    end

    // Control register storage, cleared at reset so every switch opens
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ctrl_reg <= tsc_pkg::CTRL_RESET;    // [R1]
        end
        else
        begin
            ctrl_reg <= ctrl_next;    // [R1]
        end
    end

    // Held conflict flag: set wins over a write-one clear
    always_comb
    begin
        conf_held_next = conf_held_reg;
        if (core.stat_wr && WDATA_IN[tsc_pkg::STAT_CONF_HELD])
        begin
            conf_held_next = 1'b0;
        end
        if (core.conflict)
        begin
            conf_held_next = 1'b1;    // [R5]
        end
    end

    // Conflict flag storage
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            conf_held_reg <= 1'b0;
        end
        else
        begin
            conf_held_reg <= conf_held_next;
        end
    end

    // Status word built from the evaluated paths
    always_comb
    begin
        stat_word = tsc_pkg::STAT_RESET;
        stat_word[tsc_pkg::STAT_REACH_LSB +: tsc_pkg::GROUP_N] = core.group_reach;    // [R4]
        stat_word[tsc_pkg::STAT_DIRECT]    = core.direct_reach;
        stat_word[tsc_pkg::STAT_CAL1]      = ctrl_reg[tsc_pkg::BIT_CAL1];
        stat_word[tsc_pkg::STAT_CONF_LIVE] = core.conflict;
        stat_word[tsc_pkg::STAT_CONF_HELD] = conf_held_reg;
    end

    // Read data selected now and shown for one cycle only
    always_comb
    begin
        rdata_next = tsc_pkg::READ_IDLE;
        if (core.ctrl_rd)
        begin
            rdata_next = ctrl_reg;    // [R13]
        end
        else if (core.stat_rd)
        begin
            rdata_next = stat_word;
        end
    end

    // Read data register; unmapped reads return zero
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rdata_reg <= tsc_pkg::READ_IDLE;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA_OUT = rdata_reg;

    // Switch controls driven straight from the stored bits
    assign CAL_RESISTOR_ONE_SWITCH_OUT       = ctrl_reg[tsc_pkg::BIT_CAL1];      // [R2] [R13]
    assign DIRECT_DRIVE_ELECTRODE_SWITCH_OUT = ctrl_reg[tsc_pkg::BIT_DIRECT];    // [R3] [R4]
    assign GROUP_PATH_SWITCH_OUT             = ctrl_reg[tsc_pkg::BIT_GROUP];     // [R4]
    assign SPARE_GROUP_SWITCH_OUT            = ctrl_reg[tsc_pkg::BIT_SPARE];     // [R6]
    assign CAL_TO_DRIVE_ELECTRODE_SWITCH_OUT = ctrl_reg[tsc_pkg::BIT_CAL_DE];    // [R7]
    assign SENSE_ELECTRODE_SWITCH_OUT        = ctrl_reg[tsc_pkg::BIT_SENSE];     // [R8]
    assign ANALOG_INPUT_THREE_SWITCH_OUT     = ctrl_reg[tsc_pkg::BIT_ANALOG_INPUT_PIN_THREE];      // [R9]
    assign ANALOG_INPUT_TWO_SWITCH_OUT       = ctrl_reg[tsc_pkg::BIT_ANALOG_INPUT_PIN_TWO];      // [R10]
    assign ANALOG_INPUT_ONE_SWITCH_OUT       = ctrl_reg[tsc_pkg::BIT_ANALOG_INPUT_PIN_ONE];      // [R11]
    assign ANALOG_INPUT_ZERO_SWITCH_OUT      = ctrl_reg[tsc_pkg::BIT_ANALOG_INPUT_PIN_ZERO];      // [R12]

    // Held conflict shown on a pin for the system
    assign PATH_CONFLICT_OUT = conf_held_reg;

endmodule

//--- testbench/tsc_switch_ctrl_chk.sv
`timescale 1ns/1ns
module tsc_switch_ctrl_chk (
    input wire logic        CORE_CLK_IN,                        // Clock
    input wire logic        RST_N_IN,                           // Reset
    input wire logic [31:0] ADDR_IN,                            // Address
    input wire logic [31:0] WDATA_IN,                           // Write data
    input wire logic        WR_EN_IN,                           // Write strobe
    input wire logic        RD_EN_IN,                           // Read strobe
    input wire logic [31:0] RDATA_OUT,                          // Read data
    input wire logic        CAL_RESISTOR_ONE_SWITCH_OUT,        // Bit 11
    input wire logic        DIRECT_DRIVE_ELECTRODE_SWITCH_OUT,  // Bit 9
    input wire logic        GROUP_PATH_SWITCH_OUT               // Bit 8
);
    logic [31:0] ctrl_reg;
    logic        ctrl_wr;
    // Expected register content, reserved bits dropped
    assign ctrl_wr = WR_EN_IN && (ADDR_IN == tsc_pkg::CTRL_ADDR);
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            ctrl_reg <= 32'h0000_0000;
        else if (ctrl_wr)
            ctrl_reg <= WDATA_IN & 32'h0000_0B7F;
    end
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    chk_reset_open: assert property (
        $rose(RST_N_IN) |-> !GROUP_PATH_SWITCH_OUT && !DIRECT_DRIVE_ELECTRODE_SWITCH_OUT
            && !CAL_RESISTOR_ONE_SWITCH_OUT && RDATA_OUT == 32'h0000_0000)
        else $error("switch closed after reset");
    chk_cal_one_follow: assert property (
        CAL_RESISTOR_ONE_SWITCH_OUT == ctrl_reg[11])
        else $error("cal one switch wrong");
    chk_direct_write: assert property (
        ctrl_wr |=> DIRECT_DRIVE_ELECTRODE_SWITCH_OUT == $past(WDATA_IN[9]))
        else $error("direct switch wrong");
    chk_group_write: assert property (
        ctrl_wr |=> GROUP_PATH_SWITCH_OUT == $past(WDATA_IN[8]))
        else $error("group switch wrong");
    chk_switch_hold: assert property (
        !ctrl_wr |=> $stable(DIRECT_DRIVE_ELECTRODE_SWITCH_OUT))
        else $error("switch moved without write");
    chk_ctrl_readback: assert property (
        RD_EN_IN && ADDR_IN == tsc_pkg::CTRL_ADDR |=> RDATA_OUT == $past(ctrl_reg))
        else $error("control readback wrong");
    chk_read_idle: assert property (
        !RD_EN_IN |=> RDATA_OUT == 32'h0000_0000)
        else $error("read data not idle");
    chk_unmapped_read: assert property (
        RD_EN_IN && ADDR_IN != tsc_pkg::CTRL_ADDR && ADDR_IN != tsc_pkg::STAT_ADDR
            |=> RDATA_OUT == 32'h0000_0000)
        else $error("unmapped read not zero");
    cov_cal_write: cover property (ctrl_wr && WDATA_IN[11]);
    cov_read_data: cover property (RD_EN_IN ##1 RDATA_OUT != 32'h0000_0000);
    cov_both_paths: cover property (GROUP_PATH_SWITCH_OUT && DIRECT_DRIVE_ELECTRODE_SWITCH_OUT);
endmodule
bind tsc_switch_ctrl tsc_switch_ctrl_chk tsc_switch_ctrl_chk_i (.CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_EN_IN(WR_EN_IN),
    .RD_EN_IN(RD_EN_IN), .RDATA_OUT(RDATA_OUT),
    .CAL_RESISTOR_ONE_SWITCH_OUT(CAL_RESISTOR_ONE_SWITCH_OUT),
    .DIRECT_DRIVE_ELECTRODE_SWITCH_OUT(DIRECT_DRIVE_ELECTRODE_SWITCH_OUT),
    .GROUP_PATH_SWITCH_OUT(GROUP_PATH_SWITCH_OUT));

//--- testbench/tsc_switch_ctrl_tb.sv
`timescale 1ns/1ns
module tsc_switch_ctrl_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] exp_ctrl = 32'h0000_0000;
    logic [31:0] d;
    logic [11:0] sw;
    logic        conf;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #2 clk = ~clk;
    tsc_switch_ctrl tsc_switch_ctrl_i (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_EN_IN(wr), .RD_EN_IN(rd), .RDATA_OUT(rdata),
        .CAL_RESISTOR_ONE_SWITCH_OUT(sw[11]), .DIRECT_DRIVE_ELECTRODE_SWITCH_OUT(sw[9]),
        .GROUP_PATH_SWITCH_OUT(sw[8]), .SPARE_GROUP_SWITCH_OUT(sw[6]),
        .CAL_TO_DRIVE_ELECTRODE_SWITCH_OUT(sw[5]), .SENSE_ELECTRODE_SWITCH_OUT(sw[4]),
        .ANALOG_INPUT_THREE_SWITCH_OUT(sw[3]), .ANALOG_INPUT_TWO_SWITCH_OUT(sw[2]),
        .ANALOG_INPUT_ONE_SWITCH_OUT(sw[1]), .ANALOG_INPUT_ZERO_SWITCH_OUT(sw[0]),
        .PATH_CONFLICT_OUT(conf));
    // Unused switch positions of the gathered word are tied open
    assign {sw[10], sw[7]} = 2'b00;
    // Expected control word after a write of v to address a
    function automatic logic [31:0] ctrl_after(input logic [31:0] a, input logic [31:0] v,
                                               input logic [31:0] old);
        return (a == tsc_pkg::CTRL_ADDR) ? (v & tsc_pkg::CTRL_MASK) : old;
    endfunction
    // Compare read data against an expected word
    task automatic chk_read(input string name, input logic [31:0] e);
        check_count++;
        if (rdata !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, e, rdata);
        end
    endtask
    // Compare the switch outputs picked by a mask against the model
    task automatic chk_sw(input string name, input logic [11:0] m);
        check_count++;
        if ((sw & m) !== (exp_ctrl[11:0] & m))
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp_ctrl[11:0] & m, sw & m);
        end
    endtask
    // Compare the held conflict pin
    task automatic chk_conf(input string name, input logic e);
        check_count++;
        if (conf !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", name, e, conf);
        end
    endtask
    // Write cycle; model keeps only the implemented bits
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        exp_ctrl = ctrl_after(a, v, exp_ctrl);
        #1 chk_sw("path switches", 12'hB00);
        chk_sw("group switches", 12'h07F);
    endtask
    // Read cycle; data stands one cycle, then idles at zero
    task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_read("read data", e);
        @(posedge clk);
        #1 chk_read("read idle", 32'h0000_0000);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(78));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(tsc_pkg::CTRL_ADDR, 32'h0000_0000);
        // Walking one over every bit, reserved ones included
        for (int i = 0; i < 32; i++)
        begin
            wr_reg(tsc_pkg::CTRL_ADDR, 32'h0000_0001 << i);
            rd_reg(tsc_pkg::CTRL_ADDR, exp_ctrl);
        end
        // Random words that keep the two paths apart; every third to a random address
        for (int i = 0; i < 60; i++)
        begin
            d = $urandom();
            if (d[tsc_pkg::BIT_GROUP])
                d[tsc_pkg::BIT_DIRECT] = 1'b0;
            wr_reg((i % 3 == 0) ? d : tsc_pkg::CTRL_ADDR, d);
            rd_reg(tsc_pkg::CTRL_ADDR, exp_ctrl);
        end
        chk_conf("conflict idle", 1'b0);
        // Write then read with no idle cycle between the strobes
        @(posedge clk);
        addr  <= tsc_pkg::CTRL_ADDR;
        wdata <= 32'hFFFF_FA15;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        exp_ctrl = ctrl_after(tsc_pkg::CTRL_ADDR, 32'hFFFF_FA15, exp_ctrl);
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_read("back to back read", exp_ctrl);
        chk_sw("back to back switches", 12'hB00);
        // Both paths closed at once; a status clear loses to the live conflict
        wr_reg(tsc_pkg::CTRL_ADDR, 32'hFFFF_FFFF);
        rd_reg(tsc_pkg::STAT_ADDR, 32'h0000_03FF);
        chk_conf("conflict held", 1'b1);
        wr_reg(tsc_pkg::STAT_ADDR, 32'h0000_0200);
        chk_conf("set beats clear", 1'b1);
        // Group path closed gates the group switches into the status
        wr_reg(tsc_pkg::CTRL_ADDR, 32'h0000_0115);
        rd_reg(tsc_pkg::STAT_ADDR, 32'h0000_0215);
        wr_reg(tsc_pkg::STAT_ADDR, 32'h0000_0200);
        chk_conf("conflict cleared", 1'b0);
        // Group path open: only the direct and calibration bits show, then an unmapped read
        wr_reg(tsc_pkg::CTRL_ADDR, 32'h0000_0A7F);
        rd_reg(tsc_pkg::STAT_ADDR, 32'h0000_00C0);
        rd_reg(32'h0000_2160, 32'h0000_0000);
        // Reset in mid-run opens every switch and drops the held flag
        wr_reg(tsc_pkg::CTRL_ADDR, 32'hFFFF_FFFF);
        @(posedge clk);
        rst_n <= 1'b0;
        exp_ctrl = tsc_pkg::CTRL_RESET;
        #1 chk_sw("reset path switches", 12'hB00);
        chk_sw("reset group switches", 12'h07F);
        chk_conf("reset conflict", 1'b0);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_RESET);
        finish_test();
    end
endmodule
